// ---- core/sdc_ctrl_regs.sv ----
`timescale 1ns/10ps
module sdc_ctrl_regs
  import sdc_pkg::*;
#(
  parameter int CACHE_KB   = 32,
  parameter int CACHE_WAYS = 4,
  parameter int MAIN_TRANSLATION_BUFFER_WAYS  = 4
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output      logic [31:0] rdData,
  output      sdc_size_t   icacheSize,
  output      sdc_size_t   dcacheSize,
  output      sdc_size_t   mtlbSize,
  output      sdc_size_t   btbSize,
  output      logic [4:0]  busRatioNum,
  output      logic [1:0]  busRatioDen,
  output      logic        codeUnassigned
);

  // ********************************************************
  // Build-time checks
  // ********************************************************
  // Downsizing hardware has no meaning for other shapes
  if (CACHE_WAYS != 4 || MAIN_TRANSLATION_BUFFER_WAYS != 4) begin : g_waysChk
    $error("sizing needs four-way cache and main TLB");
  end
  if (CACHE_KB != 32 && CACHE_KB != 64) begin : g_kbChk
    $error("sizing needs 32 or 64 KB caches");
  end

  // ********************************************************
  // Decoders
  // ********************************************************
  // Four-way cache or main TLB; codes 4-7 fall back to full
  function automatic sdc_size_t decodeSet(input logic [2:0] code);
    sdc_size_t s;
    s = '{ways: 3'h4, divLog2: 2'h0};
    case (code)
      SDC_CODE_HALF_LOW:  s = '{ways: 3'h2, divLog2: 2'h1};
      SDC_CODE_HALF_KEEP: s = '{ways: 3'h4, divLog2: 2'h1};
      SDC_CODE_QUARTER:   s = '{ways: 3'h2, divLog2: 2'h2};
      default:            s = '{ways: 3'h4, divLog2: 2'h0};
    endcase
    return s;
  endfunction

  // Two-way branch buffer shape
  function automatic sdc_size_t decodeBtb(input logic [2:0] code);
    sdc_size_t s;
    s = '{ways: 3'h2, divLog2: 2'h0};
    case (code)
      SDC_CODE_HALF_LOW:  s = '{ways: 3'h1, divLog2: 2'h1};
      SDC_CODE_HALF_KEEP: s = '{ways: 3'h2, divLog2: 2'h1};
      SDC_CODE_QUARTER:   s = '{ways: 3'h1, divLog2: 2'h2};
      default:            s = '{ways: 3'h2, divLog2: 2'h0};
    endcase
    return s;
  endfunction

  // ********************************************************
  // State update
  // ********************************************************
  sdc_state_t stateQ;
  sdc_state_t stateD;
  logic [31:0] ctrlView;
  logic [31:0] statView;

  // Register images as software sees them
  always_comb begin
    ctrlView = '0;
    ctrlView[SDC_IC_LSB +: SDC_FIELD_W] = stateQ.icSel;
    ctrlView[SDC_DC_LSB +: SDC_FIELD_W] = stateQ.dcSel;
    ctrlView[SDC_MT_LSB +: SDC_FIELD_W] = stateQ.mtSel;
    ctrlView[SDC_BT_LSB +: SDC_FIELD_W] = stateQ.btSel;
    statView = '0;
    statView[SDC_ST_UNASSIGNED] = stateQ.unassigned;
    statView[SDC_ST_MEM_UNITY]  = 1'b1;
  end

  // Next state; decoded shapes follow the new codes at once
  always_comb begin
    stateD = stateQ;
    if (wrStb && addr == SDC_OFS_SIZE_CTRL) begin
      // Upper bits are dropped so reserved stays zero
      stateD.icSel = wrData[SDC_IC_LSB +: SDC_FIELD_W];
      stateD.dcSel = wrData[SDC_DC_LSB +: SDC_FIELD_W];
      stateD.mtSel = wrData[SDC_MT_LSB +: SDC_FIELD_W];
      stateD.btSel = wrData[SDC_BT_LSB +: SDC_FIELD_W];
    end
    // Illegal ratio codes are refused, old ratio kept
    if (wrStb && addr == SDC_OFS_BUS_RATIO &&
        wrData[31:4] == 28'h0 && wrData[3:0] <= SDC_RATIO_LAST) begin
      stateD.ratioSel = wrData[3:0];
    end
    stateD.icSize   = decodeSet(stateD.icSel);
    stateD.dcSize   = decodeSet(stateD.dcSel);
    stateD.mtSize   = decodeSet(stateD.mtSel);
    stateD.btSize   = decodeBtb(stateD.btSel);
    // Divider outside the core takes this ratio
    stateD.ratioNum = SDC_RATIO_NUM[stateD.ratioSel];
    stateD.ratioDen = SDC_RATIO_DEN[stateD.ratioSel];
    // Flags software misuse of codes 4 to 7
    stateD.unassigned = stateD.icSel[2] | stateD.dcSel[2] |
                        stateD.mtSel[2] | stateD.btSel[2];
    // Read data valid for one cycle only
    stateD.rdData = '0;
    if (rdStb) begin
      case (addr)
        SDC_OFS_SIZE_CTRL: stateD.rdData = ctrlView;
        SDC_OFS_BUS_RATIO: stateD.rdData = {28'h0, stateQ.ratioSel};
        SDC_OFS_STATUS:    stateD.rdData = statView;
        default:           stateD.rdData = '0;
      endcase
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stateQ          <= '0;
      stateQ.icSel    <= SDC_SIZE_CTRL_RST[SDC_IC_LSB +: SDC_FIELD_W];
      stateQ.dcSel    <= SDC_SIZE_CTRL_RST[SDC_DC_LSB +: SDC_FIELD_W];
      stateQ.mtSel    <= SDC_SIZE_CTRL_RST[SDC_MT_LSB +: SDC_FIELD_W];
      stateQ.btSel    <= SDC_SIZE_CTRL_RST[SDC_BT_LSB +: SDC_FIELD_W];
      stateQ.ratioSel <= SDC_RATIO_RST;
      stateQ.icSize   <= decodeSet(SDC_CODE_FULL);
      stateQ.dcSize   <= decodeSet(SDC_CODE_FULL);
      stateQ.mtSize   <= decodeSet(SDC_CODE_FULL);
      stateQ.btSize   <= decodeBtb(SDC_CODE_FULL);
      stateQ.ratioNum <= SDC_RATIO_NUM[SDC_RATIO_RST];
      stateQ.ratioDen <= SDC_RATIO_DEN[SDC_RATIO_RST];
    end else begin
      stateQ <= stateD;
    end
  end

  // Outputs straight from the state register
  assign rdData         = stateQ.rdData;
  assign icacheSize     = stateQ.icSize;
  assign dcacheSize     = stateQ.dcSize;
  assign mtlbSize       = stateQ.mtSize;
  assign btbSize        = stateQ.btSize;
  assign busRatioNum    = stateQ.ratioNum;
  assign busRatioDen    = stateQ.ratioDen;
  assign codeUnassigned = stateQ.unassigned;

  // ********************************************************
  // Assertions
  // ********************************************************
  a_main_translation_buffer_reset_zero: assert property (@(posedge clock)
    !rst_b |=> mtlbSize.ways == 3'h4 && mtlbSize.divLog2 == 2'h0
               && stateQ.mtSel == 3'h0)
    else $error("main TLB size not full after reset");

  a_main_translation_buffer_half_two: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL && wrData[8:6] == 3'h1)
    |=> mtlbSize.ways == 3'h2 && mtlbSize.divLog2 == 2'h1)
    else $error("main TLB code 1 shape wrong");

  a_main_translation_buffer_half_four: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.mtSel == 3'h2 |-> mtlbSize == sdc_size_t'{3'h4, 2'h1})
    else $error("main TLB code 2 shape wrong");

  a_icache_quarter: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.icSel == 3'h3 |-> icacheSize == sdc_size_t'{3'h2, 2'h2})
    else $error("cache code 3 shape wrong");

  a_btb_full_two: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.btSel == 3'h0 |-> btbSize == sdc_size_t'{3'h2, 2'h0})
    else $error("branch buffer code 0 shape wrong");

  a_btb_half_direct: assert property (@(posedge clock)
    disable iff (!rst_b)
    $changed(stateQ.btSel) && stateQ.btSel == 3'h1
    |-> btbSize.ways == 3'h1 && btbSize.divLog2 == 2'h1)
    else $error("branch buffer code 1 shape wrong");

  a_btb_quarter_dm: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.btSel == 3'h3 |-> btbSize == sdc_size_t'{3'h1, 2'h2})
    else $error("branch buffer code 3 shape wrong");

  a_btb_readback: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL)
    ##1 (rdStb && addr == SDC_OFS_SIZE_CTRL)
    |=> rdData[11:9] == $past(wrData[11:9], 2))
    else $error("branch field readback mismatch");

  a_icache_field: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL)
    |=> stateQ.icSel == $past(wrData[2:0]))
    else $error("cache field not written");

  a_reserved_zero: assert property (@(posedge clock)
    disable iff (!rst_b)
    (rdStb && addr == SDC_OFS_SIZE_CTRL) |=> rdData[31:12] == 20'h0)
    else $error("reserved bits read nonzero");

  a_ratio_legal: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.ratioSel <= SDC_RATIO_LAST && busRatioDen != 2'h0
    && busRatioNum != 5'h0)
    else $error("bus ratio outside the allowed set");

  a_mem_unity: assert property (@(posedge clock)
    disable iff (!rst_b)
    (rdStb && addr == SDC_OFS_STATUS) |=> rdData[SDC_ST_MEM_UNITY])
    else $error("memory port ratio not unity");

  a_icache_reset: assert property (@(posedge clock)
    !rst_b |=> icacheSize == sdc_size_t'{3'h4, 2'h0}
               && stateQ.icSel == 3'h0)
    else $error("cache size not full after reset");

  a_btb_reset_zero: assert property (@(posedge clock)
    !rst_b |=> btbSize == sdc_size_t'{3'h2, 2'h0}
               && stateQ.btSel == 3'h0)
    else $error("branch buffer not full after reset");

  a_ratio_reset: assert property (@(posedge clock)
    !rst_b |=> stateQ.ratioSel == SDC_RATIO_RST && rdData == 32'h0
               && !codeUnassigned)
    else $error("ratio or read data not cleared by reset");

  a_main_translation_buffer_field: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL)
    |=> stateQ.mtSel == $past(wrData[SDC_MT_LSB +: SDC_FIELD_W]))
    else $error("main TLB field not written");

  a_dcache_field: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL)
    |=> stateQ.dcSel == $past(wrData[SDC_DC_LSB +: SDC_FIELD_W]))
    else $error("data cache field not written");

  a_btb_field: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL)
    |=> stateQ.btSel == $past(wrData[SDC_BT_LSB +: SDC_FIELD_W]))
    else $error("branch field not written");

  a_icache_half_two: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.icSel == 3'h1 |-> icacheSize == sdc_size_t'{3'h2, 2'h1})
    else $error("cache code 1 shape wrong");

  a_icache_half_four: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.icSel == 3'h2 |-> icacheSize == sdc_size_t'{3'h4, 2'h1})
    else $error("cache code 2 shape wrong");

  a_main_translation_buffer_quarter: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.mtSel == 3'h3 |-> mtlbSize == sdc_size_t'{3'h2, 2'h2})
    else $error("main TLB code 3 shape wrong");

  a_btb_half_two: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.btSel == 3'h2 |-> btbSize == sdc_size_t'{3'h2, 2'h1})
    else $error("branch buffer code 2 shape wrong");

  a_dcache_quarter: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.dcSel == 3'h3 |-> dcacheSize == sdc_size_t'{3'h2, 2'h2})
    else $error("data cache code 3 shape wrong");

  a_unassigned_set: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL
     && (wrData[2] || wrData[5] || wrData[8] || wrData[11]))
    |=> codeUnassigned)
    else $error("unassigned code not flagged");

  a_unassigned_clear: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_SIZE_CTRL
     && !(wrData[2] || wrData[5] || wrData[8] || wrData[11]))
    |=> !codeUnassigned)
    else $error("unassigned flag raised for legal codes");

  a_main_translation_buffer_code_high: assert property (@(posedge clock)
    disable iff (!rst_b)
    stateQ.mtSel[2] |-> mtlbSize == sdc_size_t'{3'h4, 2'h0})
    else $error("main TLB high code not full size");

  a_ratio_refused: assert property (@(posedge clock)
    disable iff (!rst_b)
    (wrStb && addr == SDC_OFS_BUS_RATIO
     && (wrData[31:4] != 28'h0 || wrData[3:0] > SDC_RATIO_LAST))
    |=> $stable(stateQ.ratioSel))
    else $error("illegal ratio write not refused");

  a_rd_idle_zero: assert property (@(posedge clock)
    disable iff (!rst_b)
    !rdStb |=> rdData == 32'h0)
    else $error("read data not zero without a read");

endmodule

// ---- core/sdc_pkg.sv ----
// Functional notes
// - Main TLB field bits 8:6, reset zero
// - Code 1: half capacity, two ways
// - Code 2: half capacity, four ways
// - Code 3: quarter capacity, two ways
// - Branch buffer field bits 11:9, full two-way
// - Branch code 1 direct, code 2 two-way halves
// - Branch code 3: quarter capacity, direct-mapped
// - Branch field read-write, clears at reset
// - Downsizing only for four-way cache and TLB
// - Downsizing needs 32 or 64 KB caches
// - Bus clock ratio from the listed set
// - Memory port runs at core clock
// - Instruction cache field bits 2:0, reset zero
package sdc_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0]  SDC_OFS_SIZE_CTRL  = 8'h00;
  localparam logic [7:0]  SDC_OFS_BUS_RATIO  = 8'h04;
  localparam logic [7:0]  SDC_OFS_STATUS     = 8'h08;
  localparam logic [31:0] SDC_SIZE_CTRL_RST  = 32'h0000_0000;

  // Field positions of the sizing register
  localparam int SDC_IC_LSB = 0;
  localparam int SDC_DC_LSB = 3;
  localparam int SDC_MT_LSB = 6;
  localparam int SDC_BT_LSB = 9;
  localparam int SDC_FIELD_W = 3;

  // Status register bits
  localparam int SDC_ST_UNASSIGNED = 0;
  localparam int SDC_ST_MEM_UNITY  = 1;

  // ********************************************************
  // Sizing codes and decoded shape
  // ********************************************************
  localparam logic [2:0] SDC_CODE_FULL       = 3'h0;
  localparam logic [2:0] SDC_CODE_HALF_LOW   = 3'h1;
  localparam logic [2:0] SDC_CODE_HALF_KEEP  = 3'h2;
  localparam logic [2:0] SDC_CODE_QUARTER    = 3'h3;

  typedef struct packed {
    logic [2:0] ways;     // Effective associativity
    logic [1:0] divLog2;  // Capacity = maximum >> divLog2
  } sdc_size_t;

  // ********************************************************
  // Core to bus clock ratios, index is the register code
  // ********************************************************
  localparam int         SDC_RATIO_N    = 15;
  localparam logic [3:0] SDC_RATIO_LAST = 4'he;
  localparam logic [3:0] SDC_RATIO_RST  = 4'h0;
  localparam logic [4:0] SDC_RATIO_NUM [SDC_RATIO_N] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h03, 5'h05,
    5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h12, 5'h14};
  localparam logic [1:0] SDC_RATIO_DEN [SDC_RATIO_N] = '{
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};

  typedef struct packed {
    logic [2:0]  icSel;
    logic [2:0]  dcSel;
    logic [2:0]  mtSel;
    logic [2:0]  btSel;
    logic [3:0]  ratioSel;
    logic [31:0] rdData;
    sdc_size_t   icSize;
    sdc_size_t   dcSize;
    sdc_size_t   mtSize;
    sdc_size_t   btSize;
    logic [4:0]  ratioNum;
    logic [1:0]  ratioDen;
    logic        unassigned;
  } sdc_state_t;

endpackage

// ---- tb/sdc_ctrl_regs_tb_top.sv ----
`timescale 1ns/10ps
module sdc_ctrl_regs_tb_top;
  import sdc_pkg::*;

  // ****************************************************
  // Signals and reference model state
  // ****************************************************
  logic        clock;
  logic        rst_b;
  logic        wrStb;
  logic        rdStb;
  logic [7:0]  addr;
  logic [31:0] wrData;
  logic [31:0] rdData;
  logic        codeUnassigned;
  sdc_size_t   icacheSize;
  sdc_size_t   dcacheSize;
  sdc_size_t   mtlbSize;
  sdc_size_t   btbSize;
  logic [4:0]  busRatioNum;
  logic [1:0]  busRatioDen;
  logic [15:0] lfsr;
  logic [31:0] rnd;
  int          n_fail;
  int          samples_checked;
  int          cycles;
  int          ic, dc, mt, bt, ratio;
  int rNum[$] = '{1, 2, 3, 4, 5, 6, 3, 5, 8, 10, 12, 14, 15, 18, 20};
  int rDen[$] = '{1, 1, 1, 1, 1, 1, 2, 2, 1, 1, 1, 1, 1, 1, 1};

  sdc_ctrl_regs i_sdc_ctrl_regs (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .icacheSize(icacheSize), .dcacheSize(dcacheSize),
    .mtlbSize(mtlbSize), .btbSize(btbSize), .busRatioNum(busRatioNum),
    .busRatioDen(busRatioDen), .codeUnassigned(codeUnassigned));

  // Shape {ways, divLog2}; unassigned codes fall back to full size
  function automatic logic [4:0] cShape(int c);
    case (c)
      1: return 5'h09;
      2: return 5'h11;
      3: return 5'h0a;
      default: return 5'h10;
    endcase
  endfunction

  function automatic logic [4:0] bShape(int c);
    case (c)
      1: return 5'h05;
      2: return 5'h09;
      3: return 5'h06;
      default: return 5'h08;
    endcase
  endfunction

  function automatic logic [15:0] step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // ****************************************************
  // Bus and compare tasks
  // ****************************************************
  // One cycle per call, so back-to-back strobes never double-drive
  task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wrData <= d;
    @(posedge clock);
    #1;
  endtask

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrSize(logic [31:0] d);
    bus(1'b1, 1'b0, 8'h00, d);
    ic = int'(d[2:0]);
    dc = int'(d[5:3]);
    mt = int'(d[8:6]);
    bt = int'(d[11:9]);
  endtask

  // Read right after the last write, then every shape against the model
  task automatic checkAll();
    logic [31:0] img;
    img = {20'h0, 3'(bt), 3'(mt), 3'(dc), 3'(ic)};
    bus(1'b0, 1'b1, 8'h00, 32'h0);
    chk("sizeReg", rdData, img);
    bus(1'b0, 1'b1, 8'h08, 32'h0);
    chk("status", rdData, {30'h0, 1'b1, 1'(ic > 3 || dc > 3 || mt > 3 ||
        bt > 3)});
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("rdIdle", rdData, 32'h0);
    chk("icShape", 32'(icacheSize), 32'(cShape(ic)));
    chk("dcShape", 32'(dcacheSize), 32'(cShape(dc)));
    chk("mtShape", 32'(mtlbSize), 32'(cShape(mt)));
    chk("btShape", 32'(btbSize), 32'(bShape(bt)));
    chk("ratio", 32'({busRatioNum, busRatioDen}),
        32'({5'(rNum[ratio]), 2'(rDen[ratio])}));
    chk("unassigned", 32'(codeUnassigned),
        32'(ic > 3 || dc > 3 || mt > 3 || bt > 3));
  endtask

  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************
  // Clock and watchdog
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Run needs well under 1000 cycles; a hang stops here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("BAD timeout exp %0d seen %0d", 4999, cycles);
      end_sim();
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {rst_b, wrStb, rdStb, addr, wrData} = '0;
    {n_fail, samples_checked, cycles, ic, dc, mt, bt, ratio} = '0;
    lfsr = 16'hab2d;
    repeat (5) @(posedge clock);
    #1;
    rst_b <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    checkAll();
    // Every code in every field, reserved bits set
    for (int c = 0; c < 8; c++) begin
      wrSize(32'hffff_f000 | 32'((((c + 3) % 8) << 9) |
             (((c + 2) % 8) << 6) | (((c + 1) % 8) << 3) | c));
      checkAll();
    end
    repeat (20) begin
      lfsr = step(lfsr);
      rnd[31:16] = lfsr;
      lfsr = step(lfsr);
      rnd[15:0] = lfsr;
      wrSize(rnd);
      checkAll();
    end
    // All ratio codes; 15 and dirty upper bits must be ignored
    for (int i = 0; i < 17; i++) begin
      bus(1'b1, 1'b0, 8'h04, (i == 16) ? 32'h0000_0011 : 32'(i));
      if (i < 15) ratio = i;
      bus(1'b0, 1'b1, 8'h04, 32'h0);
      chk("ratioReg", rdData, 32'(ratio));
      checkAll();
    end
    bus(1'b1, 1'b0, 8'h3c, 32'hffff_ffff);
    bus(1'b0, 1'b1, 8'h3c, 32'h0);
    chk("unmapped", rdData, 32'h0);
    checkAll();
    // Reset in mid-run clears every field
    rst_b <= 1'b0;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    rst_b <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    {ic, dc, mt, bt, ratio} = '0;
    checkAll();
    end_sim();
  end
endmodule
